//--- logic/bem_pkg.sv
/*
  Shared constants and carriers of the block RAM error monitor.
  Assumes a 32-bit word memory with a 39-bit SECDED code word.
*/
`default_nettype none

package bem_pkg;
  localparam int DATA_W = 32;
  localparam int PAR_W = 6;
  localparam int CHK_W = 7;
  localparam int CODE_W = 39;
  localparam int LADDR_W = 16;
  localparam int PADDR_W = 8;
  localparam int CNT_W_DEF = 10;
  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CE_COUNT = 8'h04;
  localparam logic [7:0] OFF_CE_ADDR = 8'h08;
  localparam logic [7:0] OFF_UE_ADDR = 8'h0c;
  localparam logic [7:0] OFF_INJ_DATA = 8'h10;
  localparam logic [7:0] OFF_INJ_CHECK = 8'h14;
  localparam int ST_CE_BIT = 0;
  localparam int ST_UE_BIT = 1;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic RST_FLAG = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic en;
    logic we;
    logic [LADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bem_req_t;

  typedef struct packed {
    logic valid;
    logic ce;
    logic ue;
    logic [DATA_W-1:0] data;
  } bem_rsp_t;
endpackage

`default_nettype wire

//--- logic/bem_secded.sv
/*
  Combinational SECDED encoder and decoder, 32 data bits, 39-bit code.
  Assumes the caller registers whatever it needs; nothing here is clocked.
*/
`default_nettype none
`timescale 1ns/100ps

module bem_secded (
  input wire logic [bem_pkg::DATA_W-1:0] enc_data,
  output logic [bem_pkg::CODE_W-1:0] enc_code,
  input wire logic [bem_pkg::CODE_W-1:0] dec_code,
  output logic [bem_pkg::DATA_W-1:0] dec_data,
  output logic dec_ce,
  output logic dec_ue
);
  import bem_pkg::*;

  logic [CODE_W-1:0] eh;
  logic [PAR_W-1:0] syn;
  logic ovr;
  logic [CODE_W-1:0] fix;

  // Bit 0 is overall parity, powers of two hold Hamming parity
  always_comb begin : enc_p
    int k;
    k = 0;
    eh = '0;
    for (int j = 1; j < CODE_W; j++) begin
      if ((j & (j - 1)) != 0) begin
        eh[j] = enc_data[k];
        k++;
      end
    end
    for (int i = 0; i < PAR_W; i++) begin
      for (int j = 1; j < CODE_W; j++) begin
        if (j[i] && j != (1 << i)) begin
          eh[1 << i] = eh[1 << i] ^ eh[j];
        end
      end
    end
    eh[0] = ^eh[CODE_W-1:1];
    enc_code = eh;
  end

  // A zero syndrome with odd parity is a flip of the overall bit itself
  always_comb begin : dec_p
    int k;
    k = 0;
    syn = '0;
    for (int i = 0; i < PAR_W; i++) begin
      for (int j = 1; j < CODE_W; j++) begin
        if (j[i]) begin
          syn[i] = syn[i] ^ dec_code[j];
        end
      end
    end
    ovr = ^dec_code;
    fix = dec_code;
    dec_ce = 1'b0;
    dec_ue = 1'b0;
    if (ovr) begin
      if (syn < PAR_W'(CODE_W)) begin
        fix[syn] = ~fix[syn];
        dec_ce = 1'b1;
      end else begin
        dec_ue = 1'b1;
      end
    end else if (syn != '0) begin
      dec_ue = 1'b1;
    end
    dec_data = '0;
    for (int j = 1; j < CODE_W; j++) begin
      if ((j & (j - 1)) != 0) begin
        dec_data[k] = fix[j];
        k++;
      end
    end
  end
endmodule // bem_secded

`default_nettype wire

//--- logic/bem_ctrl.sv
/*
  ECC protected word memory with APB error registers.
  Assumes a processor port on pclk that issues one word access per cycle,
  and an APB master on the same clock.
*/
// Added by the designer: the address map and the APB register port.
// Overview of operation
// - Single-bit errors are corrected before read data returns to the processor.
// - Uncorrectable read errors raise the error signal toward the processor.
// - Minimal build exposes no error registers but still corrects and signals.
// - Optional saturating counter of correctable errors, width set at build.
// - Optional capture of the first correctable error address.
// - Optional status flag set by each correctable error.
// - Correctable-error interrupt exists only when the status option is built.
// - Full build adds uncorrectable address capture and fault injection masks.
`default_nettype none
`timescale 1ns/100ps

module bem_ctrl #(
  parameter int ADDR_W = 6,
  parameter int CE_COUNT_W = bem_pkg::CNT_W_DEF,
  parameter bit STATUS_PRESENT = 1'b1,
  parameter bit CE_CAPTURE_PRESENT = 1'b1,
  parameter bit UNCORRECTABLE_ADDR_CAPTURE_PRESENT = 1'b1,
  parameter bit ERROR_INJECTION_PRESENT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bem_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bem_pkg::bem_req_t mem_req,
  output bem_pkg::bem_rsp_t mem_rsp,
  output logic ce_irq
);
  import bem_pkg::*;

  localparam int CW = (CE_COUNT_W > 0) ? CE_COUNT_W : 1;
  localparam logic [CW-1:0] CNT_MAX = '1;
  localparam bit MINIMAL = (CE_COUNT_W == 0) && !STATUS_PRESENT && !CE_CAPTURE_PRESENT
                           && !UNCORRECTABLE_ADDR_CAPTURE_PRESENT && !ERROR_INJECTION_PRESENT;

  if (ADDR_W < 1 || ADDR_W > LADDR_W || CE_COUNT_W < 0 || CE_COUNT_W > 32) begin : g_bad
    $error("bem_ctrl: ADDR_W or CE_COUNT_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory and code path
  logic [CODE_W-1:0] mem [2**ADDR_W];
  logic [CODE_W-1:0] wr_code;
  logic [DATA_W-1:0] dec_data;
  logic dec_ce;
  logic dec_ue;
  logic [DATA_W-1:0] inj_data;
  logic [CHK_W-1:0] inj_chk;

  wire logic [ADDR_W-1:0] mem_idx = mem_req.addr[ADDR_W-1:0];
  wire logic rd_take = mem_req.en & ~mem_req.we;
  wire logic wr_take = mem_req.en & mem_req.we;
  wire logic [CODE_W-1:0] rd_code = mem[mem_idx];
  wire logic [CODE_W-1:0] inj_word = ERROR_INJECTION_PRESENT ? {inj_chk, inj_data} : '0;
  wire logic ce_evt = rd_take & dec_ce;
  wire logic ue_evt = rd_take & dec_ue;

  bem_secded u_secded (
    .enc_data(mem_req.wdata),
    .enc_code(wr_code),
    .dec_code(rd_code),
    .dec_data(dec_data),
    .dec_ce(dec_ce),
    .dec_ue(dec_ue)
  );

  always_ff @(posedge pclk) begin
    if (wr_take) begin
      mem[mem_idx] <= wr_code ^ inj_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rsp <= '0;
    end else begin
      mem_rsp <= '{valid: rd_take, ce: ce_evt, ue: ue_evt, data: dec_data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state so read data comes from a flop
  logic ack;
  logic ce_status;
  logic ue_status;
  logic [CW-1:0] ce_cnt;
  logic [ADDR_W-1:0] ce_addr;
  logic [ADDR_W-1:0] ue_addr;

  function automatic logic reg_present(input logic [PADDR_W-1:0] a);
    case (a)
      OFF_STATUS: reg_present = STATUS_PRESENT;
      OFF_CE_COUNT: reg_present = (CE_COUNT_W != 0);
      OFF_CE_ADDR: reg_present = CE_CAPTURE_PRESENT;
      OFF_UE_ADDR: reg_present = UNCORRECTABLE_ADDR_CAPTURE_PRESENT;
      OFF_INJ_DATA, OFF_INJ_CHECK: reg_present = ERROR_INJECTION_PRESENT;
      default: reg_present = 1'b0;
    endcase
  endfunction

  wire logic acc = psel & penable;
  wire logic done = acc & ack;
  wire logic hit = done & pwrite & reg_present(paddr);
  wire logic st_wr = hit & (paddr == OFF_STATUS);
  wire logic clr_ce = st_wr & pwdata[ST_CE_BIT];
  wire logic clr_ue = st_wr & pwdata[ST_UE_BIT];
  wire logic cnt_clr = hit & (paddr == OFF_CE_COUNT);
  wire logic [31:0] rd_mux =
    !reg_present(paddr) ? RST_WORD :
    (paddr == OFF_STATUS) ? {30'h0000_0000, ue_status, ce_status} :
    (paddr == OFF_CE_COUNT) ? 32'(ce_cnt) :
    (paddr == OFF_CE_ADDR) ? 32'(ce_addr) :
    (paddr == OFF_UE_ADDR) ? 32'(ue_addr) :
    (paddr == OFF_INJ_DATA) ? inj_data : 32'(inj_chk);

  assign pready = ack;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= 1'b0;
      prdata <= RST_WORD;
      pslverr <= 1'b0;
    end else begin
      ack <= acc & ~ack;
      if (acc & ~ack) begin
        prdata <= rd_mux;
        pslverr <= ~reg_present(paddr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Error bookkeeping; a new event beats a clear in the same cycle
  wire logic cap_ce = ce_evt & (~ce_status | clr_ce);
  wire logic cap_ue = ue_evt & (~ue_status | clr_ue);
  wire logic next_ce_status = ce_evt | (ce_status & ~clr_ce);
  wire logic next_ue_status = ue_evt | (ue_status & ~clr_ue);
  wire logic [CW-1:0] next_ce_cnt =
    cnt_clr ? CW'(ce_evt) :
    (ce_evt && ce_cnt != CNT_MAX) ? ce_cnt + 1'b1 : ce_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_status <= RST_FLAG;
      ue_status <= RST_FLAG;
      ce_cnt <= '0;
    end else begin
      ce_status <= next_ce_status;
      ue_status <= next_ue_status;
      ce_cnt <= (CE_COUNT_W != 0) ? next_ce_cnt : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_addr <= '0;
      ue_addr <= '0;
    end else begin
      if (CE_CAPTURE_PRESENT && cap_ce) begin
        ce_addr <= mem_idx;
      end
      if (UNCORRECTABLE_ADDR_CAPTURE_PRESENT && cap_ue) begin
        ue_addr <= mem_idx;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inj_data <= RST_WORD;
      inj_chk <= '0;
    end else begin
      if (hit && paddr == OFF_INJ_DATA) begin
        inj_data <= pwdata;
      end
      if (hit && paddr == OFF_INJ_CHECK) begin
        inj_chk <= pwdata[CHK_W-1:0];
      end
    end
  end

  assign ce_irq = STATUS_PRESENT & ce_status;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  fix_data_a: assert property (rd_take |=> mem_rsp.valid && (mem_rsp.ue ||
    mem_rsp.data == $past(dec_data))) else $error("read data not corrected");
  ue_signal_a: assert property (ue_evt |=> mem_rsp.valid && mem_rsp.ue)
    else $error("uncorrectable error not signalled");
  minimal_regs_a: assert property ((MINIMAL && done) |-> pslverr && prdata == '0)
    else $error("minimal build exposes a register");
  count_inc_a: assert property (
    (CE_COUNT_W != 0 && ce_evt && !cnt_clr && ce_cnt != CNT_MAX)
    |=> ce_cnt == $past(ce_cnt) + 1'b1) else $error("counter missed an error");
  count_sat_a: assert property ((ce_cnt == CNT_MAX && !cnt_clr) |=> ce_cnt == CNT_MAX)
    else $error("counter wrapped");
  ce_capture_a: assert property ((CE_CAPTURE_PRESENT && ce_evt && !ce_status)
    |=> ce_addr == $past(mem_idx)) else $error("first failing address not captured");
  addr_hold_a: assert property ((ce_status && !clr_ce) |=> $stable(ce_addr))
    else $error("captured address changed while flag set");
  ce_flag_a: assert property (
    ce_evt |=> ce_status[*2] or (ce_status ##1 $past(clr_ce)))
    else $error("status flag not set");
  irq_gate_a: assert property (ce_evt |=> (ce_irq == STATUS_PRESENT))
    else $error("interrupt wrong for build");
  inject_a: assert property (wr_take |=> mem[$past(mem_idx)] == ($past(wr_code) ^
    $past(inj_word))) else $error("injection mask not applied");

  ce_read_c: cover property (rd_take && dec_ce ##1 mem_rsp.valid);
  ue_read_c: cover property (ue_evt ##1 ue_status);
  sat_c: cover property (ce_cnt == CNT_MAX && ce_evt);
  clear_c: cover property (ce_status ##1 clr_ce ##1 !ce_status);
endmodule // bem_ctrl

`default_nettype wire

//--- verif/bem_cpu_model.sv
/*
  Processor-side model issuing word reads and writes on the memory port.
  Assumes the block answers a read one cycle after the request edge.
*/
`default_nettype none
`timescale 1ns/100ps

module bem_cpu_model (
  input wire logic pclk,
  output var bem_pkg::bem_req_t mem_req,
  input wire bem_pkg::bem_rsp_t mem_rsp
);
  import bem_pkg::*;
  initial mem_req = '0;
  // Idle port shows inverted values so stale data cannot pass
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    mem_req <= '{1'b1, 1'b1, a, d};
    @(posedge pclk);
    mem_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [15:0] a, output bem_rsp_t r);
    @(posedge pclk);
    mem_req <= '{1'b1, 1'b0, a, 32'h0};
    @(posedge pclk);
    mem_req <= '{1'b0, 1'b0, ~a, 32'hffff_ffff};
    @(posedge pclk);
    r = mem_rsp;
  endtask
endmodule // bem_cpu_model

`default_nettype wire

//--- verif/tb_bram_ecc_error_monitor.sv
/*
  Self-checking bench: APB master, processor model, reference model.
  Assumes one clock; a minimal build shares all inputs with the full one.
*/
`default_nettype none
`timescale 1ns/100ps

module tb_bram_ecc_error_monitor;
  import bem_pkg::*;
  localparam int CNT_W = 3;
  localparam int CNT_MAX = (1 << CNT_W) - 1;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, min_rdata, seed = 32'hc, inj_d = '0;
  logic pready, pslverr, ce_irq, min_err, min_irq, nirq_irq, m_ce = 0, m_ue = 0;
  logic [6:0] inj_c = '0;
  logic [31:0] mdl_mem [64];
  bem_req_t mem_req;
  bem_rsp_t mem_rsp, min_rsp, nirq_rsp, rsp;
  int n_mismatch = 0, checked = 0, cyc = 0, cnt = 0, ce_a = 0, ue_a = 0;
  int bad [64];
  always #25 pclk = ~pclk;
  bem_ctrl #(.CE_COUNT_W(CNT_W)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_rsp, .ce_irq);
  bem_ctrl #(.CE_COUNT_W(0), .STATUS_PRESENT(1'b0), .CE_CAPTURE_PRESENT(1'b0),
    .UNCORRECTABLE_ADDR_CAPTURE_PRESENT(1'b0), .ERROR_INJECTION_PRESENT(1'b0))
    dut_min (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata(min_rdata), .pready(), .pslverr(min_err), .mem_req, .mem_rsp(min_rsp),
    .ce_irq(min_irq));
  // Status option absent, all else built: events must not reach the interrupt
  bem_ctrl #(.CE_COUNT_W(CNT_W), .STATUS_PRESENT(1'b0)) dut_nirq (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .mem_req,
    .mem_rsp(nirq_rsp), .ce_irq(nirq_irq));
  bem_cpu_model cpu (.pclk, .mem_req, .mem_rsp);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic x);
    checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t flag got %h exp %h", $time, g, x);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    cmp_flag(min_err, 1'b1);
    cmp_word(min_rdata, '0);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp_flag(e, 1'b0);
    if (a == OFF_STATUS) begin
      m_ce &= ~d[ST_CE_BIT];
      m_ue &= ~d[ST_UE_BIT];
    end
    if (a == OFF_CE_COUNT) cnt = 0;
    if (a == OFF_INJ_DATA) inj_d = d;
    if (a == OFF_INJ_CHECK) inj_c = d[6:0];
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, '0, r, e);
    cmp_flag(e, 1'b0);
    cmp_word(r, x);
  endtask
  task automatic mwrite(input logic [15:0] a, input logic [31:0] d);
    cpu.wr(a, d);
    mdl_mem[a[5:0]] = d;
    bad[a[5:0]] = $countones({inj_c, inj_d});
  endtask
  task automatic mread(input logic [15:0] a);
    logic ce;
    logic ue;
    cpu.rd(a, rsp);
    ce = (bad[a[5:0]] == 1);
    ue = (bad[a[5:0]] > 1);
    if (!ue) cmp_word(rsp.data, mdl_mem[a[5:0]]);
    cmp_flag(rsp.valid, 1'b1);
    cmp_flag(rsp.ce, ce);
    cmp_flag(rsp.ue, ue);
    cmp_word(min_rsp.data, mdl_mem[a[5:0]]);
    cmp_flag(min_rsp.ue, 1'b0);
    cmp_flag(min_irq, 1'b0);
    cmp_flag(nirq_rsp.ce, ce);
    cmp_flag(nirq_irq, 1'b0);
    if (ce && !m_ce) ce_a = a;
    if (ue && !m_ue) ue_a = a;
    m_ce |= ce;
    m_ue |= ue;
    if (ce && cnt < CNT_MAX) cnt++;
    cmp_flag(ce_irq, m_ce);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 6; i++) rreg(8'(4 * i), RST_WORD);
    apb(1'b0, 8'h18, '0, r, e);
    cmp_flag(e, 1'b1);
    cmp_word(r, '0);
    apb(1'b1, 8'h02, 32'hff, r, e);
    cmp_flag(e, 1'b1);
    for (int i = 0; i < 64; i++) mwrite(16'(i), lfsr());
    for (int i = 0; i < 64; i++) mread(16'(i));
    for (int k = 0; k < 5; k++) begin
      wreg(OFF_INJ_DATA, 32'h1 << (7 * k));
      mwrite(16'(20 + k), lfsr());
    end
    wreg(OFF_INJ_DATA, '0);
    wreg(OFF_INJ_CHECK, 32'h40);
    rreg(OFF_INJ_CHECK, 32'h40);
    mwrite(16'd25, lfsr());
    wreg(OFF_INJ_CHECK, '0);
    wreg(OFF_INJ_DATA, 32'h3);
    mwrite(16'd30, lfsr());
    wreg(OFF_INJ_DATA, '0);
    for (int i = 20; i < 31; i++) mread(16'(i));
    rreg(OFF_STATUS, 32'h3);
    rreg(OFF_UE_ADDR, 32'(ue_a));
    repeat (3) mread(16'd21);
    rreg(OFF_CE_COUNT, 32'(CNT_MAX));
    rreg(OFF_CE_ADDR, 32'd20);
    mread(16'd20);
    mwrite(16'd20, rsp.data);
    wreg(OFF_STATUS, 32'h1);
    rreg(OFF_STATUS, 32'h2);
    cmp_flag(ce_irq, 1'b0);
    wreg(OFF_CE_COUNT, '0);
    for (int i = 0; i < 64; i++) begin
      mread(16'(i));
      mwrite(16'(i), rsp.data);
    end
    rreg(OFF_CE_ADDR, 32'(ce_a));
    rreg(OFF_CE_COUNT, 32'(cnt));
    // Reset in mid-run clears flags, count and capture; memory keeps its words
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    m_ce = 0;
    m_ue = 0;
    cnt = 0;
    for (int i = 0; i < 4; i++) rreg(8'(4 * i), RST_WORD);
    cmp_flag(ce_irq, 1'b0);
    for (int i = 0; i < 64; i++) mread(16'(i));
    print_verdict();
  end
endmodule // tb_bram_ecc_error_monitor

`default_nettype wire
